// ---- rtl/dmsd_decoder.sv ----
`timescale 1ns/1ns
`default_nettype none
module dmsd_decoder
  import dmsd_pkg::*;
#(
  parameter int SRAM_D = dmsd_pkg::SRAM_DEPTH,
  parameter int SCR_D = dmsd_pkg::SCR_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Data space move from the core
  input wire logic i_dmov_req,
  input wire logic [dmsd_pkg::ADDR_W-1:0] i_dmov_addr,
  input wire logic i_dmov_we,
  input wire logic [dmsd_pkg::DATA_W-1:0] i_dmov_wdata,
  output logic o_dmov_ready,
  output logic o_dmov_done,
  output logic [dmsd_pkg::DATA_W-1:0] o_dmov_rdata,
  // External expansion bus engine
  output logic o_ext_req,
  output logic [dmsd_pkg::ADDR_W-1:0] o_ext_addr,
  output logic o_ext_we,
  output logic [dmsd_pkg::DATA_W-1:0] o_ext_wdata,
  input wire logic i_ext_done,
  input wire logic [dmsd_pkg::DATA_W-1:0] i_ext_rdata,
  // Register space access from the core
  input wire logic i_reg_req,
  input wire logic [dmsd_pkg::REG_AW-1:0] i_reg_addr,
  input wire logic i_reg_indirect,
  input wire logic i_reg_bit,
  input wire logic [2:0] i_reg_bitpos,
  input wire logic i_reg_we,
  input wire logic [dmsd_pkg::DATA_W-1:0] i_reg_wdata,
  output logic o_reg_ready,
  output logic o_reg_done,
  output logic o_reg_err,
  output logic [dmsd_pkg::DATA_W-1:0] o_reg_rdata,
  // Peripheral special function registers
  output logic o_sfr_sel,
  output logic o_sfr_we,
  output logic [dmsd_pkg::REG_AW-1:0] o_sfr_addr,
  output logic [dmsd_pkg::DATA_W-1:0] o_sfr_wdata,
  input wire logic i_sfr_hit,
  input wire logic [dmsd_pkg::DATA_W-1:0] i_sfr_rdata,
  // Program memory port
  input wire logic i_code_req,
  input wire logic [dmsd_pkg::ADDR_W-1:0] i_code_addr,
  output logic o_pmem_rd,
  output logic [dmsd_pkg::ADDR_W-1:0] o_pmem_addr,
  // State of the enable bit
  output logic o_onchip_sram_en
);
  import dmsd_pkg::*;

  localparam int SRAM_AW = $clog2(SRAM_D);
  localparam int SCR_AW = $clog2(SCR_D);

  if (SRAM_D != SRAM_DEPTH || SCR_D > (1 << REG_AW)) begin : g_bad_size
    $error("dmsd_decoder: memory sizes do not match the address map");
  end

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  typedef struct packed {
    dmsd_state_e st;
    logic sram_en;
    logic [ADDR_W-1:0] addr;
    logic we;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic done;
    logic ext_req;
    logic reg_pend;
    logic reg_scr;
    logic reg_bit;
    logic [2:0] bpos;
    logic [DATA_W-1:0] hold;
    logic [DATA_W-1:0] reg_rdata;
    logic reg_err;
    logic reg_done;
    logic pmem_rd;
    logic [ADDR_W-1:0] pmem_addr;
  } dmsd_regs_s;

  dmsd_regs_s r;
  dmsd_regs_s next_r;

  logic dmov_acc;
  logic reg_acc;
  logic is_sfr;
  logic is_pmr;
  logic bit_ok;
  logic bad_bit;
  logic [DATA_W-1:0] pmr_rd;
  logic [DATA_W-1:0] sfr_rd;
  logic [DATA_W-1:0] byte_w;
  logic sram_en_acc;
  logic scr_en;
  logic [DATA_W-1:0] sram_q;
  logic [DATA_W-1:0] scr_q;

  // -------------------------------------------------------------------------
  // Register space decode
  // -------------------------------------------------------------------------
  // Indirect access never reaches the upper registers
  assign is_sfr = !i_reg_indirect && (i_reg_addr >= SFR_BASE);
  assign is_pmr = is_sfr && (i_reg_addr == PMR_ADDR);
  assign bit_ok = (i_reg_addr[3:0] == BIT_NIB_A) ||
                  (i_reg_addr[3:0] == BIT_NIB_B);
  assign bad_bit = i_reg_bit && !(is_sfr && bit_ok);
  assign reg_acc = i_reg_req && o_reg_ready;

  // Only the enable bit exists; the others read high
  always_comb begin
    pmr_rd = UNIMPL_READ;
    pmr_rd[PMR_EN_POS] = r.sram_en;
  end

  // Absent peripheral registers read as all ones
  assign sfr_rd = is_pmr ? pmr_rd :
                  (i_sfr_hit ? i_sfr_rdata : UNIMPL_READ);

  // Bit write merges one bit into the current byte
  always_comb begin
    byte_w = sfr_rd;
    if (i_reg_bit) begin
      byte_w[i_reg_bitpos] = i_reg_wdata[0];
    end else begin
      byte_w = i_reg_wdata;
    end
  end

  // Peripheral strobes follow the request in the same cycle
  assign o_sfr_sel = reg_acc && is_sfr && !is_pmr && !bad_bit;
  assign o_sfr_we = o_sfr_sel && i_reg_we;
  assign o_sfr_addr = i_reg_addr;
  assign o_sfr_wdata = byte_w;

  // Scratchpad serves byte accesses at direct low and any indirect address
  assign scr_en = reg_acc && !is_sfr && !bad_bit;

  // -------------------------------------------------------------------------
  // Data space move decode
  // -------------------------------------------------------------------------
  assign dmov_acc = i_dmov_req && o_dmov_ready;
  // Route uses the enable as it stood before this cycle
  assign sram_en_acc = r.sram_en && (i_dmov_addr <= SRAM_LAST);

  // -------------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.reg_done = 1'b0;
    next_r.pmem_rd = 1'b0;

    // Move sequencer
    case (r.st)
      DMSD_IDLE: begin
        if (dmov_acc) begin
          next_r.addr = i_dmov_addr;
          next_r.we = i_dmov_we;
          next_r.wdata = i_dmov_wdata;
          if (sram_en_acc) begin
            next_r.st = DMSD_INT;
          end else begin
            next_r.st = DMSD_EXT;
            next_r.ext_req = 1'b1;
          end
        end
      end
      DMSD_INT: begin
        next_r.st = DMSD_FIN;
      end
      DMSD_FIN: begin
        next_r.rdata = r.we ? r.wdata : sram_q;
        next_r.done = 1'b1;
        next_r.st = DMSD_IDLE;
      end
      DMSD_EXT: begin
        if (i_ext_done) begin
          next_r.rdata = r.we ? r.wdata : i_ext_rdata;
          next_r.done = 1'b1;
          next_r.ext_req = 1'b0;
          next_r.st = DMSD_IDLE;
        end
      end
      default: begin
        next_r.st = DMSD_IDLE;
        next_r.ext_req = 1'b0;
      end
    endcase

    // Register access: capture, then answer a cycle later
    if (reg_acc) begin
      next_r.reg_pend = 1'b1;
      next_r.reg_scr = !is_sfr;
      next_r.reg_bit = i_reg_bit;
      next_r.bpos = i_reg_bitpos;
      next_r.hold = sfr_rd;
      next_r.reg_err = bad_bit;
      if (is_pmr && i_reg_we && !bad_bit) begin
        next_r.sram_en = byte_w[PMR_EN_POS];
      end
    end else if (r.reg_pend) begin
      next_r.reg_pend = 1'b0;
      next_r.reg_done = 1'b1;
      next_r.reg_rdata = r.reg_scr ? scr_q : r.hold;
      if (r.reg_bit) begin
        next_r.reg_rdata = {7'h00, r.hold[r.bpos]};
      end
      if (r.reg_err) begin
        next_r.reg_rdata = UNIMPL_READ;
      end
    end

    // Program memory takes every fetch and code move
    if (i_code_req) begin
      next_r.pmem_rd = 1'b1;
      next_r.pmem_addr = i_code_addr;
    end
  end

  // -------------------------------------------------------------------------
  // State register
  // -------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      r <= '0;
      r.st <= DMSD_IDLE;
      r.sram_en <= PMR_EN_RESET;
    end else begin
      r <= next_r;
    end
  end

  // -------------------------------------------------------------------------
  // Memories
  // -------------------------------------------------------------------------
  // On-chip data SRAM, reachable only from the move sequencer
  dmsd_ram #(.DEPTH(SRAM_D), .AW(SRAM_AW), .DW(DATA_W)) u_sram (
    .i_ref_clk(i_ref_clk),
    .i_en(r.st == DMSD_INT),
    .i_we(r.we),
    .i_addr(r.addr[SRAM_AW-1:0]),
    .i_wdata(r.wdata),
    .o_rdata(sram_q)
  );

  // Scratchpad, a space of its own
  dmsd_ram #(.DEPTH(SCR_D), .AW(SCR_AW), .DW(DATA_W)) u_scr (
    .i_ref_clk(i_ref_clk),
    .i_en(scr_en),
    .i_we(i_reg_we),
    .i_addr(i_reg_addr[SCR_AW-1:0]),
    .i_wdata(i_reg_wdata),
    .o_rdata(scr_q)
  );

  // -------------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------------
  assign o_dmov_ready = (r.st == DMSD_IDLE);
  assign o_dmov_done = r.done;
  assign o_dmov_rdata = r.rdata;
  assign o_ext_req = r.ext_req;
  assign o_ext_addr = r.addr;
  assign o_ext_we = r.we;
  assign o_ext_wdata = r.wdata;
  assign o_reg_ready = !r.reg_pend;
  assign o_reg_done = r.reg_done;
  assign o_reg_err = r.reg_err && r.reg_done;
  assign o_reg_rdata = r.reg_rdata;
  assign o_pmem_rd = r.pmem_rd;
  assign o_pmem_addr = r.pmem_addr;
  assign o_onchip_sram_en = r.sram_en;

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  int_route_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    dmov_acc && r.sram_en && i_dmov_addr <= SRAM_LAST |=>
    r.st == DMSD_INT && !o_ext_req)
    else $error("low move with SRAM enabled went outside");

  ext_dis_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    dmov_acc && !r.sram_en |=> o_ext_req && o_ext_addr == $past(i_dmov_addr))
    else $error("move with SRAM disabled not issued outside");

  ext_high_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    dmov_acc && i_dmov_addr > SRAM_LAST |=> o_ext_req)
    else $error("move above the SRAM window stayed inside");

  rst_clear_a: assert property (@(posedge i_ref_clk)
    i_sys_rst |=> !o_onchip_sram_en)
    else $error("enable bit set after reset");

  int_done_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    r.st == DMSD_INT |=> !o_dmov_done ##1 o_dmov_done && o_dmov_ready)
    else $error("internal move not finished in two cycles");

  sfr_indir_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    reg_acc && i_reg_indirect |-> !o_sfr_sel && scr_en == !i_reg_bit)
    else $error("indirect access reached a special register");

  bit_nibble_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    reg_acc && i_reg_bit && i_reg_addr[2:0] != 3'h0 |=>
    ##1 o_reg_done && o_reg_err)
    else $error("bit access allowed at wrong nibble");

  unimpl_one_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    reg_acc && is_sfr && !is_pmr && !i_sfr_hit && !i_reg_bit |=>
    ##1 o_reg_done && o_reg_rdata == 8'hff)
    else $error("absent register did not read ones");

  pmem_fetch_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_code_req |=> o_pmem_rd && o_pmem_addr == $past(i_code_addr))
    else $error("program memory did not take the fetch");

  en_late_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    dmov_acc && !r.sram_en && i_dmov_addr <= SRAM_LAST |=> o_ext_req)
    else $error("enable change reached the same move");

endmodule // dmsd_decoder
`default_nettype wire

// ---- rtl/dmsd_pkg.sv ----
// ---------------------------------------------------------------------------
// Shared constants of the data memory space decoder
// ---------------------------------------------------------------------------
package dmsd_pkg;

  // Bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int REG_AW = 8;

  // On-chip data SRAM window at the bottom of the data space
  localparam int SRAM_DEPTH = 1024;
  localparam logic [15:0] SRAM_FIRST = 16'h0000;
  localparam logic [15:0] SRAM_LAST = 16'h03ff;
  localparam logic [15:0] DATA_LAST = 16'hffff;

  // Register space: scratchpad below, special function registers above
  localparam int SCR_DEPTH = 256;
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] PMR_ADDR = 8'hc4;
  localparam int PMR_EN_POS = 0;
  localparam logic PMR_EN_RESET = 1'b0;
  localparam logic [7:0] UNIMPL_READ = 8'hff;

  // Bit-addressable special function registers end in these nibbles
  localparam logic [3:0] BIT_NIB_A = 4'h0;
  localparam logic [3:0] BIT_NIB_B = 4'h8;

  // Sequencer states for a data space move
  typedef enum logic [1:0] {
    DMSD_IDLE = 2'b00,
    DMSD_INT = 2'b01,
    DMSD_FIN = 2'b10,
    DMSD_EXT = 2'b11
  } dmsd_state_e;

endpackage

// ---- rtl/dmsd_ram.sv ----
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------------------
// Single-port synchronous byte memory, read data one cycle after enable
// ---------------------------------------------------------------------------
module dmsd_ram #(
  parameter int DEPTH = 1024,
  parameter int AW = 10,
  parameter int DW = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_en,
  input wire logic i_we,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  output logic [DW-1:0] o_rdata
);

  logic [DW-1:0] mem [DEPTH];

  if (DEPTH > (1 << AW) || DEPTH < 2) begin : g_bad_depth
    $error("dmsd_ram: depth does not fit the address width");
  end

  // Read-first: a write cycle also reads and returns the old contents
  always_ff @(posedge i_ref_clk) begin
    if (i_en) begin
      if (i_we) begin
        mem[i_addr] <= i_wdata;
      end
      o_rdata <= mem[i_addr];
    end
  end

endmodule // dmsd_ram
`default_nettype wire

// ---- tb/dmsd_ext_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------------------
// External data memory behind the expansion bus engine
// ---------------------------------------------------------------------------
module dmsd_ext_model (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_ext_req,
  input wire logic [15:0] i_ext_addr,
  input wire logic i_ext_we,
  input wire logic [7:0] i_ext_wdata,
  input wire logic [1:0] i_delay,
  output logic o_ext_done = 1'b0,
  output logic [7:0] o_ext_rdata = 8'h00
);
  logic [7:0] mem [0:65535];
  logic busy = 1'b0;
  logic [1:0] cnt = 2'h0;

  // Whole 64K space holds an address pattern at start
  initial begin
    for (int a = 0; a < 65536; a++) begin
      mem[a] = 8'(a ^ (a >> 8));
    end
  end

  // Answer after a chosen number of wait cycles; idle data toggles
  always @(posedge i_ref_clk) begin
    o_ext_done <= 1'b0;
    o_ext_rdata <= ~o_ext_rdata;
    if (i_sys_rst) begin
      busy <= 1'b0;
    end else if (i_ext_req && !busy) begin
      busy <= 1'b1;
      cnt <= i_delay;
    end else if (busy && cnt != 2'h0) begin
      cnt <= cnt - 2'h1;
    end else if (busy && !o_ext_done) begin
      o_ext_done <= 1'b1;
      o_ext_rdata <= mem[i_ext_addr];
      if (i_ext_we) begin
        mem[i_ext_addr] <= i_ext_wdata;
      end
    end else if (busy) begin
      busy <= 1'b0;
    end
  end
endmodule // dmsd_ext_model
`default_nettype wire

// ---- tb/tb_data_memory_space_decoder.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_data_memory_space_decoder;
  import dmsd_pkg::*;
  logic i_ref_clk = 1'b0, i_sys_rst = 1'b1;
  logic i_dmov_req = 1'b0, i_dmov_we = 1'b0, o_dmov_ready, o_dmov_done;
  logic [15:0] i_dmov_addr = 16'h0000, o_ext_addr, i_code_addr = 16'h0000;
  logic [7:0] i_dmov_wdata = 8'h00, o_dmov_rdata, o_ext_wdata, i_ext_rdata;
  logic o_ext_req, o_ext_we, i_ext_done, i_code_req = 1'b0, o_pmem_rd;
  logic i_reg_req = 1'b0, i_reg_ind = 1'b0, i_reg_bit = 1'b0, i_reg_we = 1'b0;
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
  logic [2:0] i_reg_bitpos = 3'h0;
  logic o_reg_ready, o_reg_done, o_reg_err, o_sfr_sel, o_sfr_we, o_sram_en;
  logic [7:0] o_sfr_addr, o_sfr_wdata, sfr90 = 8'h00, last_d, q;
  logic [15:0] o_pmem_addr;
  logic [1:0] ext_delay = 2'h0;
  logic e;
  integer seed = 32'h8664;
  int fails = 0, samples_checked = 0;

  always #20 i_ref_clk = ~i_ref_clk;

  dmsd_decoder u_dut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_dmov_req(i_dmov_req), .i_dmov_addr(i_dmov_addr),
    .i_dmov_we(i_dmov_we), .i_dmov_wdata(i_dmov_wdata),
    .o_dmov_ready(o_dmov_ready), .o_dmov_done(o_dmov_done),
    .o_dmov_rdata(o_dmov_rdata), .o_ext_req(o_ext_req),
    .o_ext_addr(o_ext_addr), .o_ext_we(o_ext_we), .o_ext_wdata(o_ext_wdata),
    .i_ext_done(i_ext_done), .i_ext_rdata(i_ext_rdata),
    .i_reg_req(i_reg_req), .i_reg_addr(i_reg_addr),
    .i_reg_indirect(i_reg_ind), .i_reg_bit(i_reg_bit),
    .i_reg_bitpos(i_reg_bitpos), .i_reg_we(i_reg_we),
    .i_reg_wdata(i_reg_wdata), .o_reg_ready(o_reg_ready),
    .o_reg_done(o_reg_done), .o_reg_err(o_reg_err),
    .o_reg_rdata(o_reg_rdata), .o_sfr_sel(o_sfr_sel), .o_sfr_we(o_sfr_we),
    .o_sfr_addr(o_sfr_addr), .o_sfr_wdata(o_sfr_wdata),
    .i_sfr_hit(o_sfr_addr == 8'h90), .i_sfr_rdata(sfr90),
    .i_code_req(i_code_req), .i_code_addr(i_code_addr),
    .o_pmem_rd(o_pmem_rd), .o_pmem_addr(o_pmem_addr),
    .o_onchip_sram_en(o_sram_en));

  dmsd_ext_model u_ext (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_ext_req(o_ext_req), .i_ext_addr(o_ext_addr), .i_ext_we(o_ext_we),
    .i_ext_wdata(o_ext_wdata), .i_delay(ext_delay),
    .o_ext_done(i_ext_done), .o_ext_rdata(i_ext_rdata));

  // One peripheral register at 90h answers the register bus
  always @(posedge i_ref_clk) begin
    if (o_sfr_we === 1'b1 && o_sfr_addr == 8'h90) begin
      sfr90 <= o_sfr_wdata;
    end
  end

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Route expected for a move: outside unless enabled and low
  function automatic logic exp_ext(input logic [15:0] a, input logic en);
    return !(en && a <= SRAM_LAST);
  endfunction

  // Peripheral select expected for a register access
  function automatic logic exp_sel(input logic [7:0] a, input logic ind,
                                   input logic b);
    return !ind && a >= SFR_BASE && a != PMR_ADDR &&
           !(b && a[2:0] != 3'h0);
  endfunction

  // One data space move, waits for done under a bound
  task automatic dmov(input logic [15:0] a, input logic w, input logic [7:0] d,
                      output logic [7:0] r, output logic x);
    int n;
    n = 0;
    x = 1'b0;
    @(posedge i_ref_clk);
    i_dmov_req <= 1'b1;
    i_dmov_addr <= a;
    i_dmov_we <= w;
    i_dmov_wdata <= d;
    ext_delay <= 2'($random(seed));
    @(posedge i_ref_clk);
    check(o_dmov_ready, 1'b1, "move taken");
    i_dmov_req <= 1'b0;
    do begin
      @(posedge i_ref_clk);
      n++;
      if (o_ext_req === 1'b1) begin
        x = 1'b1;
        check(o_ext_addr, a, "external address");
        check(o_ext_we, w, "external direction");
        check(o_ext_wdata, d, "external data");
      end
    end while (o_dmov_done !== 1'b1 && n < 40);
    check(16'(n < 40), 16'h1, "move completion");
    r = o_dmov_rdata;
  endtask

  // Write a random byte, read it back, expect the route of the rules
  task automatic wr_rd(input logic [15:0] a, input logic en);
    logic [7:0] d;
    d = 8'($random(seed));
    dmov(a, 1'b1, d, q, e);
    check(e, exp_ext(a, en), "write route");
    dmov(a, 1'b0, 8'h00, q, e);
    check(e, exp_ext(a, en), "read route");
    check(q, d, "read back");
    last_d = d;
  endtask

  // One register space access
  task automatic racc(input logic [7:0] a, input logic ind, input logic b,
                      input logic [2:0] p, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    i_reg_req <= 1'b1;
    i_reg_addr <= a;
    i_reg_ind <= ind;
    i_reg_bit <= b;
    i_reg_bitpos <= p;
    i_reg_we <= w;
    i_reg_wdata <= d;
    @(posedge i_ref_clk);
    check(o_reg_ready, 1'b1, "register taken");
    check(o_sfr_sel, exp_sel(a, ind, b), "register select");
    i_reg_req <= 1'b0;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_reg_done !== 1'b1 && n < 10);
    check(16'(n), 16'h2, "register answer cycle");
  endtask

  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #(40 * 20000);
    fails++;
    $display("MISMATCH %0t: watchdog expired", $time);
    finish_test();
  end

  // Main sequence
  initial begin
    logic [7:0] keep0;
    repeat (5) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_ref_clk);
    check(o_sram_en, 1'b0, "enable after reset");
    $display("test reset done");
    repeat (2) wr_rd(16'h0000, 1'b0);
    keep0 = last_d;
    wr_rd(16'h03ff, 1'b0);
    wr_rd(16'hffff, 1'b0);
    repeat (4) wr_rd(16'($random(seed)), 1'b0);
    $display("test disabled routing done");
    // Enable written in the cycle a move is taken: that move keeps its route
    fork
      dmov(16'h0010, 1'b0, 8'h00, q, e);
      racc(PMR_ADDR, 1'b0, 1'b0, 3'h0, 1'b1, 8'h01);
    join
    check(e, exp_ext(16'h0010, 1'b0), "move under way");
    check(o_sram_en, 1'b1, "enable set");
    wr_rd(16'h0000, 1'b1);
    wr_rd(16'h03ff, 1'b1);
    wr_rd(16'h0400, 1'b1);
    repeat (4) wr_rd(16'($random(seed)) & 16'h03ff, 1'b1);
    repeat (2) wr_rd(16'($random(seed)) | 16'h0400, 1'b1);
    racc(PMR_ADDR, 1'b0, 1'b0, 3'h0, 1'b0, 8'h00);
    check(o_reg_rdata, 8'hff, "enable register read");
    racc(PMR_ADDR, 1'b0, 1'b0, 3'h0, 1'b1, 8'h00);
    dmov(16'h0000, 1'b0, 8'h00, q, e);
    check(e, exp_ext(16'h0000, 1'b0), "disabled low route");
    check(q, keep0, "outer memory untouched");
    $display("test enabled routing done");
    racc(8'h90, 1'b1, 1'b0, 3'h0, 1'b1, 8'h5a);
    check(sfr90, 8'h00, "indirect skips register");
    racc(8'h90, 1'b0, 1'b1, 3'h3, 1'b1, 8'h01);
    check(sfr90, 8'h08, "bit write");
    racc(8'h90, 1'b0, 1'b1, 3'h3, 1'b0, 8'h00);
    check(o_reg_rdata, 8'h01, "bit read");
    racc(8'h91, 1'b0, 1'b1, 3'h3, 1'b1, 8'h01);
    check(o_reg_err, 1'b1, "bit access refused");
    racc(8'h91, 1'b0, 1'b0, 3'h0, 1'b0, 8'h00);
    check(o_reg_rdata, 8'hff, "unimplemented read");
    racc(8'h90, 1'b1, 1'b0, 3'h0, 1'b0, 8'h00);
    check(o_reg_rdata, 8'h5a, "scratchpad indirect");
    racc(8'h90, 1'b0, 1'b0, 3'h0, 1'b0, 8'h00);
    check(o_reg_rdata, 8'h08, "register direct");
    racc(8'h30, 1'b0, 1'b0, 3'h0, 1'b1, 8'h3c);
    racc(8'h30, 1'b1, 1'b0, 3'h0, 1'b0, 8'h00);
    check(o_reg_rdata, 8'h3c, "scratchpad direct");
    $display("test register space done");
    @(posedge i_ref_clk);
    i_code_req <= 1'b1;
    i_code_addr <= 16'($random(seed));
    @(posedge i_ref_clk);
    i_code_req <= 1'b0;
    @(posedge i_ref_clk);
    check(o_pmem_rd, 1'b1, "fetch strobe");
    check(o_pmem_addr, i_code_addr, "fetch address");
    $display("test program fetch done");
    finish_test();
  end
endmodule // tb_data_memory_space_decoder
`default_nettype wire
